// file: nel_led.sv
// red network error indicator pattern generator
`timescale 1ns/10ps
`default_nettype none
// Contract
// - A process data watchdog timeout holds the red indicator steadily lit.
// - A general configuration error blinks the indicator 200 ms lit and 200 ms dark.
// - An impossible master-requested state change counts as a configuration error and blinks.
// - A booting error sets the status change flag to 0x01 and flickers 50 ms lit, 50 ms dark.
// - An autonomous state change sets the status change flag and repeats 200 ms lit, 1000 ms dark.
// - A synchronization error moves to safe-operational by itself and shows the single flash.
// - An application watchdog timeout gives two 200 ms flashes 200 ms apart, then 1000 ms dark.
module nel_led (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire nel_pkg::nel_err_t err_in,
    output logic led_red_out,
    output logic [7:0] al_change_out,
    output logic safe_op_req_out,
    output nel_pkg::nel_pat_t pattern_out
);
    import nel_pkg::*;

    // ------------------------------------------------------------
    // pattern selection
    // ------------------------------------------------------------
    nel_pat_t sel;

    // fixed priority, highest first
    always_comb begin
        if (err_in.pdi_wd_timeout) begin
            sel = NEL_PAT_ON;
        end else if (err_in.boot_error) begin
            sel = NEL_PAT_FLICKER;
        end else if (err_in.cfg_error) begin
            sel = NEL_PAT_BLINK;
        end else if (err_in.app_wd_timeout) begin
            sel = NEL_PAT_DOUBLE;
        end else if (err_in.sync_error || err_in.auto_state_change) begin
            sel = NEL_PAT_SINGLE;
        end else begin
            sel = NEL_PAT_OFF;
        end
    end

    // ------------------------------------------------------------
    // step time base
    // ------------------------------------------------------------
    nel_pat_t pat_ff;
    nel_pat_t nxt_pat;
    logic restart;
    logic tick;

    assign restart = (sel != pat_ff);

    // divider restarts with every new pattern
    nel_tick nel_tick_i (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .restart_in(restart),
        .tick_out(tick)
    );

    // ------------------------------------------------------------
    // phase sequencer
    // ------------------------------------------------------------
    nel_phase_t ph_ff;
    nel_phase_t nxt_ph;
    logic [4:0] left_ff;
    logic [4:0] nxt_left;
    logic led_ff;
    logic nxt_led;
    logic [4:0] ph_len;
    logic ph_lit;

    // ------------------------------------------------------------
    // phase tables
    // ------------------------------------------------------------
    // length of the phase about to start, in steps
    function automatic logic [4:0] phase_len(input nel_pat_t p, input nel_phase_t ph);
        logic [4:0] len;
        len = BLINK_STEPS;
        case (p)
            NEL_PAT_FLICKER: begin
                len = FLICKER_STEPS;
            end
            NEL_PAT_SINGLE: begin
                case (ph)
                    NEL_PH_OFF1: len = LONG_OFF_STEPS;
                    default: len = BLINK_STEPS;
                endcase
            end
            NEL_PAT_DOUBLE: begin
                case (ph)
                    NEL_PH_OFF2: len = LONG_OFF_STEPS;
                    default: len = BLINK_STEPS;
                endcase
            end
            NEL_PAT_BLINK: len = BLINK_STEPS;
            NEL_PAT_ON: len = BLINK_STEPS;
            NEL_PAT_OFF: len = BLINK_STEPS;
            default: len = BLINK_STEPS;
        endcase
        return len;
    endfunction

    // next phase in the cycle of a pattern
    function automatic nel_phase_t phase_next(input nel_pat_t p, input nel_phase_t ph);
        nel_phase_t n;
        n = NEL_PH_ON1;
        case (ph)
            NEL_PH_ON1: n = NEL_PH_OFF1;
            NEL_PH_OFF1: begin
                if (p == NEL_PAT_DOUBLE) begin
                    n = NEL_PH_ON2;
                end else begin
                    n = NEL_PH_ON1;
                end
            end
            NEL_PH_ON2: n = NEL_PH_OFF2;
            NEL_PH_OFF2: n = NEL_PH_ON1;
            default: n = NEL_PH_ON1;
        endcase
        return n;
    endfunction

    // indicator level in a given phase of a pattern
    function automatic logic phase_lit(input nel_pat_t p, input nel_phase_t ph);
        logic lit;
        lit = 1'b0;
        case (p)
            NEL_PAT_OFF: lit = 1'b0;
            NEL_PAT_ON: lit = 1'b1;
            default: begin
                case (ph)
                    NEL_PH_ON1: lit = 1'b1;
                    NEL_PH_ON2: lit = 1'b1;
                    default: lit = 1'b0;
                endcase
            end
        endcase
        return lit;
    endfunction

    // a change of selection restarts at the lit phase
    always_comb begin
        nxt_pat = sel;
        nxt_ph = ph_ff;
        nxt_left = left_ff;
        ph_len = 5'h00;
        ph_lit = 1'b0;
        if (restart) begin
            nxt_ph = NEL_PH_ON1;
            nxt_left = phase_len(sel, NEL_PH_ON1);
        end else if (tick) begin
            if (left_ff <= 5'h01) begin
                nxt_ph = phase_next(pat_ff, ph_ff);
                ph_len = phase_len(pat_ff, nxt_ph);
                nxt_left = ph_len;
            end else begin
                nxt_left = left_ff - 5'h01;
            end
        end
        ph_lit = phase_lit(nxt_pat, nxt_ph);
        nxt_led = ph_lit;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pat_ff <= NEL_PAT_OFF;
            ph_ff <= NEL_PH_ON1;
            left_ff <= 5'h00;
            led_ff <= 1'b0;
        end else begin
            pat_ff <= nxt_pat;
            ph_ff <= nxt_ph;
            left_ff <= nxt_left;
            led_ff <= nxt_led;
        end
    end

    // ------------------------------------------------------------
    // status change flag and safe-operational request
    // ------------------------------------------------------------
    logic [7:0] chg_ff;
    logic [7:0] nxt_chg;
    logic safe_ff;
    logic nxt_safe;

    // flag follows the sources, no latching
    always_comb begin
        nxt_safe = 1'b0;
        nxt_chg = AL_CHANGE_CLR;
        if (err_in.sync_error) begin
            nxt_safe = 1'b1;
            nxt_chg = AL_CHANGE_SET;
        end
        if (err_in.boot_error) begin
            nxt_chg = AL_CHANGE_SET;
        end
        if (err_in.auto_state_change) begin
            nxt_chg = AL_CHANGE_SET;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chg_ff <= AL_CHANGE_CLR;
            safe_ff <= 1'b0;
        end else begin
            chg_ff <= nxt_chg;
            safe_ff <= nxt_safe;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign led_red_out = led_ff;
    assign al_change_out = chg_ff;
    assign safe_op_req_out = safe_ff;
    assign pattern_out = pat_ff;
endmodule // nel_led
`default_nettype wire

// file: nel_pkg.sv
// package: constants and types for the network error led pattern block
`default_nettype none
package nel_pkg;
    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned STEP_MS = 50;
    localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    localparam logic [19:0] STEP_LAST = 20'(STEP_CYC - 1);
    // ------------------------------------------------------------
    // pattern timing, in ms and in 50 ms steps
    // ------------------------------------------------------------
    localparam int unsigned FLICKER_MS = 50;
    localparam int unsigned BLINK_MS = 200;
    localparam int unsigned LONG_OFF_MS = 1000;
    localparam logic [4:0] FLICKER_STEPS = 5'(FLICKER_MS / STEP_MS);
    localparam logic [4:0] BLINK_STEPS = 5'(BLINK_MS / STEP_MS);
    localparam logic [4:0] LONG_OFF_STEPS = 5'(LONG_OFF_MS / STEP_MS);
    // ------------------------------------------------------------
    // status change flag value
    // ------------------------------------------------------------
    localparam logic [7:0] AL_CHANGE_SET = 8'h01;
    localparam logic [7:0] AL_CHANGE_CLR = 8'h00;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NEL_PAT_OFF = 3'h0,
        NEL_PAT_ON = 3'h1,
        NEL_PAT_DOUBLE = 3'h3,
        NEL_PAT_FLICKER = 3'h2,
        NEL_PAT_SINGLE = 3'h6,
        NEL_PAT_BLINK = 3'h7
    } nel_pat_t;

    typedef enum logic [1:0] {
        NEL_PH_ON1 = 2'h0,
        NEL_PH_OFF1 = 2'h1,
        NEL_PH_ON2 = 2'h3,
        NEL_PH_OFF2 = 2'h2
    } nel_phase_t;

    typedef struct packed {
        logic pdi_wd_timeout;
        logic cfg_error;
        logic boot_error;
        logic sync_error;
        logic auto_state_change;
        logic app_wd_timeout;
    } nel_err_t;
endpackage
`default_nettype wire

// file: nel_tick.sv
// 50 ms step enable divider
`timescale 1ns/10ps
`default_nettype none
module nel_tick (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic restart_in,
    output logic tick_out
);
    import nel_pkg::*;
    logic [19:0] cnt_ff;
    logic [19:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt = cnt_ff + 20'h00001;
        if (restart_in) begin
            nxt_cnt = 20'h00000;
        end else if (cnt_ff == STEP_LAST) begin
            nxt_cnt = 20'h00000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= 20'h00000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;
endmodule // nel_tick
`default_nettype wire

// file: nel_led_monitor.sv
// checker: assertions on the indicator ports
`timescale 1ns/10ps
`default_nettype none
module nel_led_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire nel_pkg::nel_err_t err_in,
    input wire logic led_red_out,
    input wire logic [7:0] al_change_out,
    input wire logic safe_op_req_out,
    input wire nel_pkg::nel_pat_t pattern_out
);
    import nel_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic [5:0] e;
    logic flag_src;
    assign e = err_in;
    assign flag_src = |e[3:1];
    // cycles since the pattern last changed, saturating
    logic [19:0] run_ff;
    nel_pat_t prev_pat_ff;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_ff <= 20'h00000;
            prev_pat_ff <= NEL_PAT_OFF;
        end else begin
            prev_pat_ff <= pattern_out;
            if (pattern_out != prev_pat_ff) begin
                run_ff <= 20'h00000;
            end else if (run_ff != STEP_LAST) begin
                run_ff <= run_ff + 20'h00001;
            end
        end
    end
    property p_hold; pattern_out != NEL_PAT_OFF && run_ff < STEP_LAST |-> led_red_out; endproperty
    property p_on; e[5] |=> pattern_out == NEL_PAT_ON && led_red_out; endproperty
    property p_blink; !e[5] && !e[3] && e[4] |=> pattern_out == NEL_PAT_BLINK; endproperty
    property p_flick; !e[5] && e[3] |=> pattern_out == NEL_PAT_FLICKER; endproperty
    property p_flag; 1 |=> al_change_out == ($past(flag_src) ? AL_CHANGE_SET : AL_CHANGE_CLR); endproperty
    property p_single; e[5:3] == 3'h0 && !e[0] && |e[2:1] |=> pattern_out == NEL_PAT_SINGLE; endproperty
    property p_safe; e[2] |=> safe_op_req_out; endproperty
    property p_double; e[5:3] == 3'h0 && e[0] |=> pattern_out == NEL_PAT_DOUBLE; endproperty
    property p_off; e == 6'h0 |=> pattern_out == NEL_PAT_OFF && !led_red_out; endproperty
    property p_restart; $changed(pattern_out) && pattern_out != NEL_PAT_OFF |-> led_red_out; endproperty
    a_on: assert property (p_on) else $error("steady pattern wrong");
    a_blink: assert property (p_blink) else $error("blink pattern wrong");
    a_flick: assert property (p_flick) else $error("flicker pattern wrong");
    a_flag: assert property (p_flag) else $error("change flag wrong");
    a_single: assert property (p_single) else $error("single pattern wrong");
    a_safe: assert property (p_safe) else $error("safe request missing");
    a_double: assert property (p_double) else $error("double pattern wrong");
    a_off: assert property (p_off) else $error("idle pattern wrong");
    a_restart: assert property (p_restart) else $error("restart not lit");
    a_hold: assert property (p_hold) else $error("lit phase cut short");
    c_blink: cover property (pattern_out == NEL_PAT_BLINK);
    c_double: cover property (pattern_out == NEL_PAT_DOUBLE);
    c_single: cover property (pattern_out == NEL_PAT_SINGLE);
    c_flick: cover property (pattern_out == NEL_PAT_FLICKER);
endmodule // nel_led_monitor
bind nel_led nel_led_monitor nel_led_monitor_i (.ref_clk_in, .rst_in, .err_in, .led_red_out,
    .al_change_out, .safe_op_req_out, .pattern_out);
`default_nettype wire

// file: nel_lamp.sv
// model of the red lamp: counts lit onsets
`timescale 1ns/10ps
`default_nettype none
module nel_lamp (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic led_in,
    output logic [15:0] onsets_out
);
    logic prev_ff;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_ff <= 1'b0;
            onsets_out <= 16'h0;
        end else begin
            prev_ff <= led_in;
            if (led_in && !prev_ff) begin
                onsets_out <= onsets_out + 16'h1;
            end
        end
    end
endmodule // nel_lamp
`default_nettype wire

// file: test_network_error_led_pattern.sv
// testbench for the indicator pattern generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module test_network_error_led_pattern;
    import nel_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    nel_err_t err_in = '0;
    logic led_red_out;
    logic [7:0] al_change_out;
    logic safe_op_req_out;
    nel_pat_t pattern_out;
    logic [15:0] onsets;
    int err_total = 0;
    int comparisons = 0;
    nel_led nel_led_i (.ref_clk_in, .rst_in, .err_in, .led_red_out, .al_change_out,
        .safe_op_req_out, .pattern_out);
    nel_lamp nel_lamp_i (.ref_clk_in, .rst_in, .led_in(led_red_out), .onsets_out(onsets));
    initial begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic apply(input logic [5:0] e, input nel_pat_t p, input logic [7:0] f, input logic s);
        err_in = nel_err_t'(e);
        cyc(2);
        `CHK("pattern", p, pattern_out)
        `CHK("led", p != NEL_PAT_OFF, led_red_out)
        `CHK("flag", f, al_change_out)
        `CHK("safe", s, safe_op_req_out)
    endtask
    task automatic t_each();
        apply(6'h00, NEL_PAT_OFF, AL_CHANGE_CLR, 1'b0);
        apply(6'h20, NEL_PAT_ON, AL_CHANGE_CLR, 1'b0);
        apply(6'h10, NEL_PAT_BLINK, AL_CHANGE_CLR, 1'b0);
        apply(6'h08, NEL_PAT_FLICKER, AL_CHANGE_SET, 1'b0);
        apply(6'h02, NEL_PAT_SINGLE, AL_CHANGE_SET, 1'b0);
        apply(6'h04, NEL_PAT_SINGLE, AL_CHANGE_SET, 1'b1);
        apply(6'h01, NEL_PAT_DOUBLE, AL_CHANGE_CLR, 1'b0);
        $display("each pattern done");
    endtask
    task automatic t_prio();
        apply(6'h3f, NEL_PAT_ON, AL_CHANGE_SET, 1'b1);
        apply(6'h18, NEL_PAT_FLICKER, AL_CHANGE_SET, 1'b0);
        apply(6'h11, NEL_PAT_BLINK, AL_CHANGE_CLR, 1'b0);
        apply(6'h07, NEL_PAT_DOUBLE, AL_CHANGE_SET, 1'b1);
        $display("priority done");
    endtask
    task automatic t_hold();
        logic [15:0] n;
        apply(6'h10, NEL_PAT_BLINK, AL_CHANGE_CLR, 1'b0);
        n = onsets;
        cyc(60000);
        `CHK("lit phase", 1'b1, led_red_out)
        apply(6'h01, NEL_PAT_DOUBLE, AL_CHANGE_CLR, 1'b0);
        apply(6'h00, NEL_PAT_OFF, AL_CHANGE_CLR, 1'b0);
        apply(6'h02, NEL_PAT_SINGLE, AL_CHANGE_SET, 1'b0);
        `CHK("onsets", n + 16'h1, onsets)
        $display("hold done");
    endtask
    task automatic t_reset();
        apply(6'h24, NEL_PAT_ON, AL_CHANGE_SET, 1'b1);
        rst_in = 1'b1;
        cyc(1);
        `CHK("reset pattern", NEL_PAT_OFF, pattern_out)
        rst_in = 1'b0;
        apply(6'h20, NEL_PAT_ON, AL_CHANGE_CLR, 1'b0);
        $display("reset done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(100000 * 50);
        err_total++;
        summarize();
    end
    initial begin
        cyc(4);
        rst_in = 1'b0;
        t_each();
        t_prio();
        t_hold();
        t_reset();
        summarize();
    end
endmodule // test_network_error_led_pattern
`default_nettype wire
